// ### hdl/ass_defines.svh
// register offsets, field positions, command and feature codes and timing values in ns for the command block
`ifndef ASS_DEFINES_SVH
`define ASS_DEFINES_SVH

`define ASS_OFF_FEATURE 12'h000
`define ASS_OFF_SECCNT 12'h004
`define ASS_OFF_ADDR_LO 12'h008
`define ASS_OFF_ADDR_MID 12'h00c
`define ASS_OFF_ADDR_HI 12'h010
`define ASS_OFF_UNIT 12'h014
`define ASS_OFF_OPCODE 12'h018
`define ASS_OFF_ERROR 12'h01c
`define ASS_OFF_STATUS 12'h020
`define ASS_OFF_CONFIG 12'h024
`define ASS_OFF_XFER 12'h028
`define ASS_OFF_APM_LVL 12'h02c
`define ASS_OFF_AAM_LVL 12'h030
`define ASS_OFF_CTRL 12'h034

`define ASS_OP_SEEK_NIB 4'h7
`define ASS_OP_SERVICE 8'ha2
`define ASS_OP_SETFEAT 8'hef

`define ASS_FT_WC_ON 8'h02
`define ASS_FT_XFER 8'h03
`define ASS_FT_APM_ON 8'h05
`define ASS_FT_PUIS_ON 8'h06
`define ASS_FT_SPINUP 8'h07
`define ASS_FT_OFS_ON 8'h09
`define ASS_FT_AAM_ON 8'h42
`define ASS_FT_ECC52 8'h44
`define ASS_FT_RLA_OFF 8'h55
`define ASS_FT_RELI_ON 8'h5d
`define ASS_FT_REV_OFF 8'h66
`define ASS_FT_WC_OFF 8'h82
`define ASS_FT_APM_OFF 8'h85
`define ASS_FT_PUIS_OFF 8'h86
`define ASS_FT_OFS_OFF 8'h89
`define ASS_FT_RLA_ON 8'haa
`define ASS_FT_ECC4 8'hbb
`define ASS_FT_AAM_OFF 8'hc2
`define ASS_FT_REV_ON 8'hcc
`define ASS_FT_RELI_OFF 8'hdd

`define ASS_XT_PIO_DEF 5'h00
`define ASS_XT_PIO_FC 5'h01
`define ASS_XT_MDMA 5'h04
`define ASS_XT_UDMA 5'h08
`define ASS_XM_PIO_MAX 3'h4
`define ASS_XM_MDMA_MAX 3'h2
`define ASS_XM_UDMA_MAX 3'h5

`define ASS_ECC_SHORT 8'h04
`define ASS_ECC_LONG 8'h34

// error bits
`define ASS_ERR_ABT 2
`define ASS_ERR_IDN 4
// status bits
`define ASS_ST_BSY 7
`define ASS_ST_RDY 6
`define ASS_ST_DSC 4
`define ASS_ST_DRQ 3
`define ASS_ST_ERR 0
// unit register fields
`define ASS_UNIT_LBA 6

// config register bits
`define ASS_CF_WC 0
`define ASS_CF_RLA 1
`define ASS_CF_ECC52 2
`define ASS_CF_APM 3
`define ASS_CF_AAM 4
`define ASS_CF_PUIS 5
`define ASS_CF_OFS 6
`define ASS_CF_REV 7
`define ASS_CF_RELI 8
`define ASS_CF_WC_LOCK 9
`define ASS_CF_SPUN 10

// seek settle time in ns
`define ASS_SEEK_NS 200
`define ASS_CLK_NS 10

`endif

// ### hdl/ass_pkg.sv
// types shared by the seek, service and set-features command block
`default_nettype none
package ass_pkg;

    typedef enum logic [2:0] {
        ASS_IDLE = 3'b000,
        ASS_DECODE = 3'b001,
        ASS_SEEK = 3'b010,
        ASS_SERVICE = 3'b011,
        ASS_FEATURE = 3'b100,
        ASS_DONE = 3'b101
    } ass_state_t;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] mid;
        logic [7:0] high;
        logic [3:0] top;
    } ass_addr_t;

    typedef struct packed {
        logic [4:0] kind;
        logic [2:0] mode;
    } ass_xfer_t;

endpackage
`default_nettype wire

// ### hdl/ass_cmd_block.sv
// task-file command block: seek, service and set-features over an APB slave
// Behaviour
// - an opcode 7xh moves to the addressed track and selects the head.
// - seek works whether or not the media is formatted.
// - after a logical seek the current address reads back from the same registers.
// - service delivers pending transfer or status of a bus-released command.
// - set-features uses the feature value to pick the parameter to change.
// - an undefined feature value sets abort and reports an error.
// - 02h enables, 82h disables write cache; exhausted spares force cache off.
// - 55h turns look-ahead off, aah turns it back on.
// - 44h selects 52 ecc bytes for long commands, bbh restores 4.
// - 05h enables power management at the count level, 85h disables it.
// - 42h enables acoustic management at the count level, c2h disables it.
// - 06h enables standby power-up, 07h spins up, 86h disables it.
// - 09h enters address offset mode, 89h leaves it.
// - 66h/cch stop and restart reverting; 5dh/ddh switch release interrupt.
// - reset gives cache on, 4-byte ecc, look-ahead on, no reverting, no release irq.
// - for 03h the count's upper 5 bits are type, lower 3 the mode.
// - code 00h is default pio, 01h default pio with ready flow off.
// - type 01h pio modes 0-4, 04h mdma 0-2, 08h udma 0-5.
//
// Our own choices: the APB register port and the placing of the registers.
`include "ass_defines.svh"
`default_nettype none

module ass_cmd_block
    import ass_pkg::*;
#(
    parameter int unsigned SEEK_NS = `ASS_SEEK_NS,
    parameter logic [27:0] MAX_LBA = 28'hfffffff,
    parameter logic [15:0] MAX_CYL = 16'h3fff
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic spares_exhausted_i,
    input wire logic released_pending_i,
    output logic busy_o,
    output logic service_o,
    output logic spin_up_o,
    output logic head_sel_valid_o,
    output logic [27:0] seek_target_o,
    output logic [7:0] ecc_len_o
);

    localparam int unsigned SEEK_CYC_RAW = (SEEK_NS + `ASS_CLK_NS - 1) / `ASS_CLK_NS;
    localparam int unsigned SEEK_CYC = (SEEK_CYC_RAW < 1) ? 1 : SEEK_CYC_RAW;

    if (SEEK_CYC > 4096)
        $error("seek time too long for counter");

    ass_state_t state_reg;
    logic [7:0] feature_reg, seccnt_reg, unit_reg, opcode_reg, error_reg, status_reg;
    logic [7:0] apm_lvl_reg, aam_lvl_reg;
    ass_addr_t addr_reg;
    logic [10:0] config_reg;
    ass_xfer_t xfer_reg;
    logic [12:0] seek_cnt_reg;
    logic spin_reg;
    logic [27:0] target_reg;

    logic wr_en, cmd_wr, host_wr, addr_ok, xfer_ok, ft_ok, seek_in_range;
    logic [7:0] ft;
    logic [4:0] xkind;
    logic [2:0] xmode;
    logic [27:0] lba_addr;
    logic [31:0] rdata;

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    // task file is locked while busy, as on the real interface
    assign host_wr = wr_en && (state_reg == ASS_IDLE);
    assign cmd_wr = host_wr && (paddr_i == `ASS_OFF_OPCODE);

    assign ft = feature_reg;
    // bytes in address order; the struct packs them the other way round
    assign lba_addr = {addr_reg.top, addr_reg.high, addr_reg.mid, addr_reg.low};
    assign xkind = seccnt_reg[7:3];
    assign xmode = seccnt_reg[2:0];

    always_comb
    begin
        xfer_ok = 1'b0;
        if (xkind == `ASS_XT_PIO_DEF)
            xfer_ok = (xmode <= 3'h1);
        else if (xkind == `ASS_XT_PIO_FC)
            xfer_ok = (xmode <= `ASS_XM_PIO_MAX);
        else if (xkind == `ASS_XT_MDMA)
            xfer_ok = (xmode <= `ASS_XM_MDMA_MAX);
        else if (xkind == `ASS_XT_UDMA)
            xfer_ok = (xmode <= `ASS_XM_UDMA_MAX);
    end

    always_comb
    begin
        case (ft)
            `ASS_FT_WC_ON, `ASS_FT_WC_OFF, `ASS_FT_RLA_OFF, `ASS_FT_RLA_ON,
            `ASS_FT_ECC52, `ASS_FT_ECC4, `ASS_FT_APM_OFF, `ASS_FT_AAM_OFF,
            `ASS_FT_PUIS_ON, `ASS_FT_SPINUP, `ASS_FT_PUIS_OFF, `ASS_FT_OFS_ON,
            `ASS_FT_OFS_OFF, `ASS_FT_REV_OFF, `ASS_FT_REV_ON, `ASS_FT_RELI_ON,
            `ASS_FT_RELI_OFF: ft_ok = 1'b1;
            `ASS_FT_XFER: ft_ok = xfer_ok;
            // level 00h and ffh are refused
            `ASS_FT_APM_ON: ft_ok = (seccnt_reg != 8'h00) && (seccnt_reg != 8'hff);
            `ASS_FT_AAM_ON: ft_ok = (seccnt_reg >= 8'h80) && (seccnt_reg != 8'hff);
            default: ft_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        if (unit_reg[`ASS_UNIT_LBA])
            seek_in_range = (lba_addr <= MAX_LBA);
        else
            seek_in_range = ({addr_reg.high, addr_reg.mid} <= MAX_CYL);
    end

    // command sequencer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            state_reg <= ASS_IDLE;
        else
        begin
            case (state_reg)
                ASS_IDLE:
                    if (cmd_wr)
                        state_reg <= ASS_DECODE;
                ASS_DECODE:
                    if (opcode_reg[7:4] == `ASS_OP_SEEK_NIB)
                        state_reg <= ASS_SEEK;
                    else if (opcode_reg == `ASS_OP_SERVICE)
                        state_reg <= ASS_SERVICE;
                    else if (opcode_reg == `ASS_OP_SETFEAT)
                        state_reg <= ASS_FEATURE;
                    else
                        state_reg <= ASS_DONE;
                ASS_SEEK:
                    if (!seek_in_range || seek_cnt_reg == 13'h0001)
                        state_reg <= ASS_DONE;
                ASS_SERVICE, ASS_FEATURE:
                    state_reg <= ASS_DONE;
                ASS_DONE:
                    state_reg <= ASS_IDLE;
                default:
                    state_reg <= ASS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            seek_cnt_reg <= 13'h0000;
        else if (state_reg == ASS_DECODE)
            seek_cnt_reg <= 13'(SEEK_CYC);
        else if (state_reg == ASS_SEEK && seek_cnt_reg != 13'h0000)
            seek_cnt_reg <= seek_cnt_reg - 13'h0001;
    end

    // host-written task file
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            feature_reg <= 8'h00;
            seccnt_reg <= 8'h00;
            addr_reg <= '0;
            unit_reg <= 8'ha0;
            opcode_reg <= 8'h00;
        end
        else if (host_wr)
        begin
            if (paddr_i == `ASS_OFF_FEATURE)
                feature_reg <= pwdata_i[7:0];
            else if (paddr_i == `ASS_OFF_SECCNT)
                seccnt_reg <= pwdata_i[7:0];
            else if (paddr_i == `ASS_OFF_ADDR_LO)
                addr_reg.low <= pwdata_i[7:0];
            else if (paddr_i == `ASS_OFF_ADDR_MID)
                addr_reg.mid <= pwdata_i[7:0];
            else if (paddr_i == `ASS_OFF_ADDR_HI)
                addr_reg.high <= pwdata_i[7:0];
            else if (paddr_i == `ASS_OFF_UNIT)
            begin
                unit_reg <= pwdata_i[7:0];
                addr_reg.top <= pwdata_i[3:0];
            end
            else if (paddr_i == `ASS_OFF_OPCODE)
                opcode_reg <= pwdata_i[7:0];
        end
    end

    // target latched from the task file as loaded
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            target_reg <= 28'h0000000;
        // address returns in place: the task file keeps the reached position
        // no format check gates the seek
        else if (state_reg == ASS_DECODE && opcode_reg[7:4] == `ASS_OP_SEEK_NIB)
            target_reg <= lba_addr;
    end

    // error and status
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            error_reg <= 8'h00;
            status_reg <= 8'h50;
        end
        else if (state_reg == ASS_DECODE)
        begin
            error_reg <= 8'h00;
            status_reg <= 8'h80;
        end
        else if (state_reg == ASS_SEEK && !seek_in_range)
        begin
            // id not found on unreachable address
            error_reg[`ASS_ERR_IDN] <= 1'b1;
            status_reg[`ASS_ST_ERR] <= 1'b1;
        end
        // abort on undefined value, or service with nothing released
        else if ((state_reg == ASS_FEATURE && !ft_ok)
                 || (state_reg == ASS_SERVICE && !released_pending_i))
        begin
            error_reg[`ASS_ERR_ABT] <= 1'b1;
            status_reg[`ASS_ST_ERR] <= 1'b1;
        end
        else if (state_reg == ASS_DONE)
        begin
            if (opcode_reg[7:4] != `ASS_OP_SEEK_NIB && opcode_reg != `ASS_OP_SERVICE
                && opcode_reg != `ASS_OP_SETFEAT)
            begin
                error_reg[`ASS_ERR_ABT] <= 1'b1;
                status_reg[`ASS_ST_ERR] <= 1'b1;
            end
            status_reg[`ASS_ST_BSY] <= 1'b0;
            status_reg[`ASS_ST_RDY] <= 1'b1;
            status_reg[`ASS_ST_DSC] <= 1'b1;
        end
    end

    // set-features parameter flags
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            config_reg <= 11'h003;
        else
        begin
            if (spares_exhausted_i)
            begin
                config_reg[`ASS_CF_WC_LOCK] <= 1'b1;
                config_reg[`ASS_CF_WC] <= 1'b0;
            end
            if (state_reg == ASS_FEATURE && ft_ok)
            begin
                case (ft)
                    `ASS_FT_WC_ON:
                        config_reg[`ASS_CF_WC] <= !config_reg[`ASS_CF_WC_LOCK]
                                                  && !spares_exhausted_i;
                    `ASS_FT_WC_OFF: config_reg[`ASS_CF_WC] <= 1'b0;
                    `ASS_FT_RLA_OFF: config_reg[`ASS_CF_RLA] <= 1'b0;
                    `ASS_FT_RLA_ON: config_reg[`ASS_CF_RLA] <= 1'b1;
                    `ASS_FT_ECC52: config_reg[`ASS_CF_ECC52] <= 1'b1;
                    `ASS_FT_ECC4: config_reg[`ASS_CF_ECC52] <= 1'b0;
                    `ASS_FT_APM_ON: config_reg[`ASS_CF_APM] <= 1'b1;
                    `ASS_FT_APM_OFF: config_reg[`ASS_CF_APM] <= 1'b0;
                    `ASS_FT_AAM_ON: config_reg[`ASS_CF_AAM] <= 1'b1;
                    `ASS_FT_AAM_OFF: config_reg[`ASS_CF_AAM] <= 1'b0;
                    `ASS_FT_PUIS_ON: config_reg[`ASS_CF_PUIS] <= 1'b1;
                    `ASS_FT_PUIS_OFF: config_reg[`ASS_CF_PUIS] <= 1'b0;
                    `ASS_FT_SPINUP: config_reg[`ASS_CF_SPUN] <= 1'b1;
                    `ASS_FT_OFS_ON: config_reg[`ASS_CF_OFS] <= 1'b1;
                    `ASS_FT_OFS_OFF: config_reg[`ASS_CF_OFS] <= 1'b0;
                    `ASS_FT_REV_OFF: config_reg[`ASS_CF_REV] <= 1'b0;
                    `ASS_FT_REV_ON: config_reg[`ASS_CF_REV] <= 1'b1;
                    `ASS_FT_RELI_ON: config_reg[`ASS_CF_RELI] <= 1'b1;
                    `ASS_FT_RELI_OFF: config_reg[`ASS_CF_RELI] <= 1'b0;
                    // no self-hold here: it would undo a same-cycle spare lock
                    default: ;
                endcase
            end
        end
    end

    // levels and transfer mode held apart from the flag word
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            xfer_reg <= '0;
            apm_lvl_reg <= 8'h80;
            aam_lvl_reg <= 8'hfe;
        end
        else if (state_reg == ASS_FEATURE && ft_ok)
        begin
            // only a legal code reaches here
            if (ft == `ASS_FT_XFER)
                xfer_reg <= seccnt_reg;
            else if (ft == `ASS_FT_APM_ON)
                apm_lvl_reg <= seccnt_reg;
            else if (ft == `ASS_FT_AAM_ON)
                aam_lvl_reg <= seccnt_reg;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            spin_reg <= 1'b0;
        else
            spin_reg <= (state_reg == ASS_FEATURE) && ft_ok && (ft == `ASS_FT_SPINUP);
    end

    // register read mux
    always_comb
    begin
        rdata = 32'h00000000;
        addr_ok = 1'b1;
        if (paddr_i == `ASS_OFF_FEATURE || paddr_i == `ASS_OFF_OPCODE)
            rdata = 32'h00000000;
        else if (paddr_i == `ASS_OFF_SECCNT)
            rdata[7:0] = seccnt_reg;
        else if (paddr_i == `ASS_OFF_ADDR_LO)
            rdata[7:0] = addr_reg.low;
        else if (paddr_i == `ASS_OFF_ADDR_MID)
            rdata[7:0] = addr_reg.mid;
        else if (paddr_i == `ASS_OFF_ADDR_HI)
            rdata[7:0] = addr_reg.high;
        else if (paddr_i == `ASS_OFF_UNIT)
            rdata[7:0] = {unit_reg[7:4], addr_reg.top};
        else if (paddr_i == `ASS_OFF_ERROR)
            rdata[7:0] = error_reg;
        else if (paddr_i == `ASS_OFF_STATUS)
            rdata[7:0] = status_reg;
        else if (paddr_i == `ASS_OFF_CONFIG)
            rdata[10:0] = config_reg;
        else if (paddr_i == `ASS_OFF_XFER)
            rdata[7:0] = xfer_reg;
        else if (paddr_i == `ASS_OFF_APM_LVL)
            rdata[7:0] = apm_lvl_reg;
        else if (paddr_i == `ASS_OFF_AAM_LVL)
            rdata[7:0] = aam_lvl_reg;
        else
            addr_ok = 1'b0;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            prdata_o <= 32'h00000000;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= rdata;
    end

    assign busy_o = status_reg[`ASS_ST_BSY];
    // service hands back the released command
    assign service_o = (state_reg == ASS_SERVICE) && released_pending_i;
    assign spin_up_o = spin_reg;
    assign head_sel_valid_o = (state_reg == ASS_DONE) && !status_reg[`ASS_ST_ERR]
                              && (opcode_reg[7:4] == `ASS_OP_SEEK_NIB);
    assign seek_target_o = target_reg;
    assign ecc_len_o = config_reg[`ASS_CF_ECC52] ? `ASS_ECC_LONG : `ASS_ECC_SHORT;

endmodule
`default_nettype wire

// ### tb/ass_cmd_block_asserts.sv
// port-level assertions for the command block
`include "ass_defines.svh"
`default_nettype none
module ass_cmd_block_asserts
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic busy_o,
    input wire logic service_o,
    input wire logic spin_up_o,
    input wire logic head_sel_valid_o,
    input wire logic [7:0] ecc_len_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ecc_len;
        ecc_len_o == 8'h04 || ecc_len_o == 8'h34;
    endproperty
    a_ecc_len: assert property (p_ecc_len)
        else $error("ecc length neither 4 nor 52");
    property p_op_busy;
        psel_i && penable_i && pwrite_i && paddr_i == `ASS_OFF_OPCODE && !busy_o
            |-> ##[1:2] busy_o;
    endproperty
    a_op_busy: assert property (p_op_busy)
        else $error("opcode write did not raise busy");
    property p_cmd_end;
        $rose(busy_o) |-> ##[2:40] !busy_o;
    endproperty
    a_cmd_end: assert property (p_cmd_end)
        else $error("command did not finish in time");
    property p_head_pulse;
        head_sel_valid_o |=> !head_sel_valid_o;
    endproperty
    a_head_pulse: assert property (p_head_pulse)
        else $error("head select pulse too long");
    property p_head_done;
        head_sel_valid_o |-> busy_o ##[1:2] !busy_o;
    endproperty
    a_head_done: assert property (p_head_done)
        else $error("busy not cleared after seek");
    property p_spin_pulse;
        spin_up_o |=> !spin_up_o;
    endproperty
    a_spin_pulse: assert property (p_spin_pulse)
        else $error("spin-up pulse too long");
    property p_svc;
        service_o |-> busy_o ##1 !service_o;
    endproperty
    a_svc: assert property (p_svc)
        else $error("service pulse outside command");
    property p_idle;
        !busy_o |-> !head_sel_valid_o && !service_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("command pulse while idle");
endmodule
bind ass_cmd_block ass_cmd_block_asserts i_ass_cmd_block_asserts (.clk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .busy_o, .service_o, .spin_up_o,
    .head_sel_valid_o, .ecc_len_o);
`default_nettype wire

// ### tb/ass_host.sv
// host adapter model: apb master for the task-file registers
`include "ass_defines.svh"
`default_nettype none
module ass_host
(
    input wire logic clk_i,
    input wire logic pready_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end

    // idle edge at the end keeps two calls from colliding in one step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        // no cycle limit: a stuck slave is ended by the bench watchdog
        do
            @(posedge clk_i);
        while (pready_i !== 1'b1);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d;
        @(posedge clk_i);
    endtask

    task automatic load(input logic logical_address, input logic [27:0] a);
        xfer(1'b1, `ASS_OFF_ADDR_LO, {24'h0, a[7:0]});
        xfer(1'b1, `ASS_OFF_ADDR_MID, {24'h0, a[15:8]});
        xfer(1'b1, `ASS_OFF_ADDR_HI, {24'h0, a[23:16]});
        xfer(1'b1, `ASS_OFF_UNIT, {24'h0, 1'b1, logical_address, 2'b10, a[27:24]});
    endtask
endmodule
`default_nettype wire

// ### tb/test_ass_cmd_block.sv
// self-checking bench for the command block
`include "ass_defines.svh"
`default_nettype none
module test_ass_cmd_block
    import ass_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic spares_exhausted_i = 1'b0;
    logic released_pending_i = 1'b0;
    logic busy_o, service_o, spin_up_o, head_sel_valid_o;
    logic [27:0] seek_target_o, sa;
    logic [7:0] ecc_len_o;
    logic [32:0] expq[$];
    int n_mismatch = 0;
    int num_checks = 0;
    int n_head = 0;
    int n_svc = 0;
    int n_spin = 0;
    logic [19:0] ft [18] = '{20'h82002, 20'h02003, 20'h55001, 20'haa003, 20'h44007,
        20'hbb003, 20'h0500b, 20'h85003, 20'h42013, 20'hc2003, 20'h06023, 20'h86003,
        20'h09043, 20'h89003, 20'hcc083, 20'h66003, 20'h5d103, 20'hdd003};
    logic [15:0] xt [10] = '{16'h0c0c, 16'h0d0c, 16'h2222, 16'h2322, 16'h4545,
        16'h4645, 16'h0000, 16'h0101, 16'h1001, 16'h0201};

    always #5 clk_i = ~clk_i;

    ass_cmd_block #(.MAX_LBA(28'h7ffffff)) i_ass_cmd_block (.clk_i, .rst_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .spares_exhausted_i, .released_pending_i, .busy_o, .service_o, .spin_up_o,
        .head_sel_valid_o, .seek_target_o, .ecc_len_o);
    ass_host i_ass_host (.clk_i, .pready_i(pready_o), .psel_o(psel_i),
        .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // read data is taken at the edge that completes the access
    always @(posedge clk_i)
    begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && expq.size() > 0)
            check({pslverr_o, prdata_o}, expq.pop_front());
    end

    always @(posedge clk_i)
    begin
        if (head_sel_valid_o === 1'b1)
            n_head++;
        if (service_o === 1'b1)
            n_svc++;
        if (spin_up_o === 1'b1)
            n_spin++;
    end

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        i_ass_host.xfer(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_ass_host.xfer(1'b1, a, {24'h0, d});
    endtask

    task automatic run(input logic [7:0] op, input logic [7:0] st, input logic [7:0] er);
        wr(`ASS_OFF_OPCODE, op);
        // a hang here is ended by the watchdog
        do
            @(negedge clk_i);
        while (busy_o !== 1'b0);
        @(posedge clk_i);
        rd(`ASS_OFF_STATUS, {25'h0, st});
        rd(`ASS_OFF_ERROR, {25'h0, er});
    endtask

    task automatic feat(input logic [7:0] f, input logic ab);
        wr(`ASS_OFF_FEATURE, f);
        run(`ASS_OP_SETFEAT, ab ? 8'h51 : 8'h50, ab ? 8'h04 : 8'h00);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(32'hcc5bc6e4));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`ASS_OFF_CONFIG, 33'h003);
        rd(`ASS_OFF_STATUS, 33'h050);
        rd(`ASS_OFF_XFER, 33'h000);
        wr(`ASS_OFF_SECCNT, 8'h90);
        for (int i = 0; i < 18; i++)
        begin
            feat(ft[i][19:12], 1'b0);
            rd(`ASS_OFF_CONFIG, {21'h0, ft[i][11:0]});
            check({25'h0, ecc_len_o}, ft[i][2] ? 33'h34 : 33'h04);
        end
        rd(`ASS_OFF_APM_LVL, 33'h090);
        rd(`ASS_OFF_AAM_LVL, 33'h090);
        for (int i = 0; i < 3; i++)
        begin
            feat(8'h01 + 8'h7f * i[7:0], 1'b1);
            rd(`ASS_OFF_CONFIG, 33'h003);
        end
        for (int i = 0; i < 10; i++)
        begin
            wr(`ASS_OFF_SECCNT, xt[i][15:8]);
            feat(`ASS_FT_XFER, xt[i][15:8] != xt[i][7:0]);
            rd(`ASS_OFF_XFER, {25'h0, xt[i][7:0]});
        end
        feat(`ASS_FT_AAM_ON, 1'b1);
        run(8'h00, 8'h51, 8'h04);
        for (int i = 0; i < 4; i++)
        begin
            sa = $urandom & 32'h7ffffff;
            i_ass_host.load(1'b1, sa);
            run(8'h70 | i[7:0], 8'h50, 8'h00);
            check({5'h0, seek_target_o}, {5'h0, sa});
            rd(`ASS_OFF_ADDR_LO, {25'h0, sa[7:0]});
            rd(`ASS_OFF_ADDR_MID, {25'h0, sa[15:8]});
            rd(`ASS_OFF_ADDR_HI, {25'h0, sa[23:16]});
            rd(`ASS_OFF_UNIT, {25'h0, 4'he, sa[27:24]});
        end
        i_ass_host.load(1'b1, 28'h8000000);
        run(8'h7f, 8'h51, 8'h10);
        i_ass_host.load(1'b0, 28'h0ffff00);
        run(8'h70, 8'h51, 8'h10);
        released_pending_i <= 1'b1;
        run(`ASS_OP_SERVICE, 8'h50, 8'h00);
        released_pending_i <= 1'b0;
        run(`ASS_OP_SERVICE, 8'h51, 8'h04);
        rd(12'h100, 33'h100000000);
        spares_exhausted_i <= 1'b1;
        feat(`ASS_FT_WC_ON, 1'b0);
        rd(`ASS_OFF_CONFIG, 33'h202);
        feat(`ASS_FT_SPINUP, 1'b0);
        spares_exhausted_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`ASS_OFF_CONFIG, 33'h003);
        check({25'h0, ecc_len_o}, 33'h04);
        check(33'(n_head), 33'd4);
        check(33'(n_svc), 33'd1);
        check(33'(n_spin), 33'd1);
        print_verdict();
    end
endmodule
`default_nettype wire
